// file: hdl/ssb_pkg.sv
package ssb_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_BR   = 8'h04;
    localparam logic [7:0] ADR_TX   = 8'h08;
    localparam logic [7:0] ADR_RX   = 8'h0c;
    localparam logic [7:0] ADR_STAT = 8'h10;

    // =========================================================
    // sync_serial_control fields
    localparam int CTL_EN     = 0;
    localparam int CTL_MASTER = 1;
    localparam int CTL_CPOL   = 2;
    localparam int CTL_CPHA   = 3;
    localparam int CTL_LSB    = 4;
    localparam int CTL_HALF   = 5;
    localparam int CTL_WID_LO = 8;
    localparam int CTL_WID_HI = 11;

    // =========================================================
    // status fields
    localparam int STA_BUSY   = 0;
    localparam int STA_RXFULL = 1;
    localparam int STA_OVR    = 2;
    localparam int STA_TXFULL = 3;
    localparam int STA_TXEMP  = 4;
    localparam int STA_CNT_LO = 8;

    // =========================================================
    // reset values and sizes
    localparam logic [31:0] CTRL_RESET = 32'h00000f00;
    localparam logic [15:0] BR_RESET   = 16'h0001;
    localparam int          BR_W       = 16;
    localparam int          DATA_W     = 16;
    localparam int          FIFO_DEPTH = 8;
    localparam int          CPU_DIV    = 2;

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } ssb_state_e;
endpackage : ssb_pkg

// file: hdl/ssb_fifo.sv
module ssb_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    input  wire logic [W-1:0]               in_data_in,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [W-1:0]                    out_data_out,
    output logic [$clog2(DEPTH+1)-1:0]      count_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    wire           push = in_valid_in & in_ready_out;
    wire           pop  = out_valid_out & out_ready_in;

    assign in_ready_out  = (cnt_q != CW'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign count_out     = cnt_q;

    // =========================================================
    // pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
endmodule : ssb_fifo

// file: hdl/ssb_top.sv
// How it works
// - full duplex shifts out and in together; half duplex drives data only while sending
// - master makes the shift clock; slave follows clock from an external master
// - word width, bit order, clock polarity and phase come from control register
// - transmit fifo and receive holding buffer let shifts overlap software access
// - own 16-bit down counter with 16-bit reload, independent of other timers
// - counter advances on every second system clock
// - counter counts down, runs only while the global enable bit is set
// - reading reload register while enabled returns the running count
// - while disabled, reload register reads and writes the stored reload
// - bit rate equals system clock over two times (reload plus one); reload 0 gives system clock over four
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
module ssb_top #(
    parameter int DW    = ssb_pkg::DATA_W,
    parameter int DEPTH = ssb_pkg::FIFO_DEPTH
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic        SCK_IN,
    output logic             SCK_OUT,
    output logic             SCK_OE_OUT,
    output logic             SDO_OUT,
    output logic             SDO_OE_OUT,
    input  wire logic        SDI_IN,
    input  wire logic        SEL_N_IN
);
    localparam int CW = $clog2(DEPTH+1);
    localparam int BW = ssb_pkg::BR_W;

    // =========================================================
    // state
    logic [31:0]        ctrl_q;
    logic [BW-1:0]      reload_q;
    logic [BW-1:0]      cnt_q;
    logic               half_q;
    logic               ack_q;
    logic [31:0]        rdata_q;
    ssb_pkg::ssb_state_e state_q;
    logic [4:0]         edge_cnt_q;
    logic [DW-1:0]      tx_sr_q;
    logic [DW-1:0]      rx_sr_q;
    logic [DW-1:0]      rx_buf_q;
    logic               rx_full_q;
    logic               ovr_q;
    logic               sck_q;
    logic               sck_prev_q;

    // =========================================================
    // control fields
    wire       en        = ctrl_q[ssb_pkg::CTL_EN];
    wire       master    = ctrl_q[ssb_pkg::CTL_MASTER];
    wire       cpol      = ctrl_q[ssb_pkg::CTL_CPOL];
    wire       cpha      = ctrl_q[ssb_pkg::CTL_CPHA];
    wire       lsb_first = ctrl_q[ssb_pkg::CTL_LSB];
    wire       half_dup  = ctrl_q[ssb_pkg::CTL_HALF];
    wire [3:0] width_m1  = ctrl_q[ssb_pkg::CTL_WID_HI:ssb_pkg::CTL_WID_LO];

    // =========================================================
    // wishbone decode
    wire        hit_ctrl = (WB_ADR_IN[7:2] == ssb_pkg::ADR_CTRL[7:2]);
    wire        hit_br   = (WB_ADR_IN[7:2] == ssb_pkg::ADR_BR[7:2]);
    wire        hit_tx   = (WB_ADR_IN[7:2] == ssb_pkg::ADR_TX[7:2]);
    wire        hit_rx   = (WB_ADR_IN[7:2] == ssb_pkg::ADR_RX[7:2]);
    wire        hit_stat = (WB_ADR_IN[7:2] == ssb_pkg::ADR_STAT[7:2]);
    wire        req      = WB_CYC_IN & WB_STB_IN & ~ack_q;
    wire        fifo_in_ready;
    // a full fifo holds off the ack: back-pressure reaches the bus master
    wire        stall    = req & WB_WE_IN & hit_tx & ~fifo_in_ready;
    wire        ack_d    = req & ~stall;
    wire        do_wr    = ack_d & WB_WE_IN;
    wire        do_rd    = ack_d & ~WB_WE_IN;
    wire [31:0] wmask    = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    wire [31:0] ctrl_d   = (ctrl_q & ~wmask) | (WB_DAT_IN & wmask);
    wire [BW-1:0] br_new = (reload_q & ~wmask[BW-1:0]) | (WB_DAT_IN[BW-1:0] & wmask[BW-1:0]);
    wire        wr_ctrl  = do_wr & hit_ctrl;
    wire        wr_br    = do_wr & hit_br & ~en;
    wire        wr_tx    = do_wr & hit_tx;
    wire        rd_rx    = do_rd & hit_rx;
    wire        clr_ovr  = do_wr & hit_stat & WB_DAT_IN[ssb_pkg::STA_OVR] & WB_SEL_IN[0];

    // =========================================================
    // bit-rate generator
    // half-rate step
    wire        step   = en & half_q;
    // underflow reloads and ends a bit
    wire        tick   = step & (cnt_q == '0);
    wire [BW:0] mid_w  = {1'b0, reload_q} + {{BW{1'b0}}, 1'b1};
    wire [BW-1:0] mid  = mid_w[BW:1];
    // second edge half a bit later, so two clock edges fit one bit
    wire        midev  = step & (cnt_q == mid) & (mid != '0);
    wire        cnt_nz = (cnt_q != '0);

    // =========================================================
    // fifo and shift engine
    wire          fifo_out_valid;
    wire [DW-1:0] fifo_out_data;
    wire [CW-1:0] fifo_count;
    wire          shifting   = (state_q == ssb_pkg::ST_SHIFT);
    wire          idle       = (state_q == ssb_pkg::ST_IDLE);
    // master edges from the generator, slave edges from the pin
    wire          slave_edge = (SCK_IN != sck_prev_q) & ~SEL_N_IN;
    wire          edge_ev    = master ? (tick | midev) : slave_edge;
    wire          start_m    = idle & en & master & fifo_out_valid;
    wire          start_s    = idle & en & ~master & ~SEL_N_IN;
    wire          start      = start_m | start_s;
    wire          pop        = start & fifo_out_valid;
    // slave with nothing queued answers with zeros
    wire [DW-1:0] load_word  = fifo_out_valid ? fifo_out_data : '0;
    wire          last_edge  = (edge_cnt_q == {width_m1, 1'b1});
    wire          sample_edge = (edge_cnt_q[0] == cpha);
    wire          shift_edge  = ~sample_edge & ~(cpha & (edge_cnt_q == '0));
    wire          act_edge    = shifting & edge_ev;
    wire          abort       = shifting & ~master & SEL_N_IN;
    wire          done        = act_edge & last_edge & ~abort;
    wire [DW-1:0] rx_shift    = lsb_first ? {SDI_IN, rx_sr_q[DW-1:1]} : {rx_sr_q[DW-2:0], SDI_IN};
    wire [DW-1:0] rx_sr_d     = (act_edge & sample_edge) ? rx_shift : rx_sr_q;
    wire [DW-1:0] tx_shift    = lsb_first ? (tx_sr_q >> 1) : (tx_sr_q << 1);
    wire [3:0]    gap         = 4'hf - width_m1;
    wire [DW-1:0] wmask_rx    = {DW{1'b1}} >> gap;
    wire [DW-1:0] rx_word     = lsb_first ? (rx_sr_d >> gap) : (rx_sr_d & wmask_rx);
    wire          tx_bit      = lsb_first ? tx_sr_q[0] : tx_sr_q[width_m1];
    wire          busy        = shifting | fifo_out_valid;

    ssb_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_txq (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (SYS_RST_IN),
        .in_valid_in   (wr_tx),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (WB_DAT_IN[DW-1:0]),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (pop),
        .out_data_out  (fifo_out_data),
        .count_out     (fifo_count)
    );

    // =========================================================
    // read mux
    logic [31:0] stat_w;
    logic [31:0] rd_mux;
    always_comb begin
        stat_w = '0;
        stat_w[ssb_pkg::STA_BUSY]   = busy;
        stat_w[ssb_pkg::STA_RXFULL] = rx_full_q;
        stat_w[ssb_pkg::STA_OVR]    = ovr_q;
        stat_w[ssb_pkg::STA_TXFULL] = ~fifo_in_ready;
        stat_w[ssb_pkg::STA_TXEMP]  = ~fifo_out_valid;
        stat_w[ssb_pkg::STA_CNT_LO +: CW] = fifo_count;
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux = ctrl_q;
        end else if (hit_br) begin
            rd_mux[BW-1:0] = en ? cnt_q : reload_q;
        end else if (hit_rx) begin
            rd_mux[DW-1:0] = rx_buf_q;
        end else if (hit_stat) begin
            rd_mux = stat_w;
        end
    end

    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = rdata_q;
    assign SCK_OUT    = sck_q;
    assign SCK_OE_OUT = en & master;
    assign SDO_OUT    = tx_bit;
    // half duplex frees the data line between words
    assign SDO_OE_OUT = en & (master | ~SEL_N_IN) & (~half_dup | shifting);

    // =========================================================
    // bus registers
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ack_q    <= 1'b0;
            rdata_q  <= '0;
            ctrl_q   <= ssb_pkg::CTRL_RESET;
            reload_q <= ssb_pkg::BR_RESET;
        end else begin
            ack_q <= ack_d;
            if (do_rd) begin
                rdata_q <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_d;
            end
            if (wr_br) begin
                reload_q <= br_new;
            end
        end
    end

    // =========================================================
    // bit-rate counter
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            half_q <= 1'b0;
            cnt_q  <= ssb_pkg::BR_RESET;
        end else if (!en) begin
            half_q <= 1'b0;
            cnt_q  <= reload_q;
        end else begin
            half_q <= ~half_q;
            if (step) begin
                cnt_q <= cnt_nz ? cnt_q - BW'(1) : reload_q;
            end
        end
    end

    // =========================================================
    // shift engine
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q    <= ssb_pkg::ST_IDLE;
            edge_cnt_q <= '0;
            tx_sr_q    <= '0;
            rx_sr_q    <= '0;
            sck_q      <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= SCK_IN;
            rx_sr_q    <= rx_sr_d;
            case (state_q)
                ssb_pkg::ST_IDLE: begin
                    sck_q      <= cpol;
                    edge_cnt_q <= '0;
                    if (start) begin
                        tx_sr_q <= load_word;
                        state_q <= ssb_pkg::ST_SHIFT;
                    end
                end
                ssb_pkg::ST_SHIFT: begin
                    if (!en || abort) begin
                        state_q <= ssb_pkg::ST_IDLE;
                    end else if (edge_ev) begin
                        if (master) begin
                            sck_q <= ~sck_q;
                        end
                        if (shift_edge) begin
                            tx_sr_q <= tx_shift;
                        end
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                        if (last_edge) begin
                            state_q <= ssb_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ssb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // receive holding buffer; a new word wins over a same-cycle read
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rx_buf_q  <= '0;
            rx_full_q <= 1'b0;
            ovr_q     <= 1'b0;
        end else begin
            // word held while the next one shifts
            if (done) begin
                rx_buf_q <= rx_word;
            end
            rx_full_q <= done | (rx_full_q & ~rd_rx);
            ovr_q     <= (done & rx_full_q & ~rd_rx) | (ovr_q & ~clr_ovr);
        end
    end
endmodule : ssb_top

// file: testbench/ssb_assertions.sv
module ssb_assertions (
    input wire logic        SYS_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [7:0]  WB_ADR_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        WB_ACK_OUT,
    input wire logic        SCK_OUT,
    input wire logic        SCK_OE_OUT,
    input wire logic        SDO_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl_q;
    logic [15:0] br_q;
    wire logic   req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    wire logic   rd  = req && !WB_WE_IN;
    wire logic   en  = ctl_q[ssb_pkg::CTL_EN];
    wire logic   ms  = ctl_q[ssb_pkg::CTL_MASTER];
    // shadow of what software programmed; reload only lands while disabled
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ctl_q <= ssb_pkg::CTRL_RESET;
            br_q  <= ssb_pkg::BR_RESET;
        end else if (req && WB_WE_IN && WB_ADR_IN == ssb_pkg::ADR_CTRL) begin
            ctl_q <= WB_DAT_IN;
        end else if (req && WB_WE_IN && WB_ADR_IN == ssb_pkg::ADR_BR && !en) begin
            br_q <= WB_DAT_IN[15:0];
        end
    end
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    property p_ack_next; req && WB_ADR_IN != ssb_pkg::ADR_TX |=> WB_ACK_OUT; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_br_dis; rd && WB_ADR_IN == ssb_pkg::ADR_BR && !en |=> WB_DAT_OUT[15:0] == br_q; endproperty
    a_br_dis: assert property (p_br_dis) else $error("disabled reload read wrong");
    property p_br_en; rd && WB_ADR_IN == ssb_pkg::ADR_BR && en |=> WB_DAT_OUT[15:0] <= br_q; endproperty
    a_br_en: assert property (p_br_en) else $error("running count above reload");
    property p_unmapped; rd && WB_ADR_IN[7:2] > 6'h04 |=> WB_DAT_OUT == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dat_hold; !rd |=> $stable(WB_DAT_OUT); endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without read");
    property p_sck_oe; SCK_OE_OUT == (en && ms); endproperty
    a_sck_oe: assert property (p_sck_oe) else $error("clock drive not master only");
    property p_sdo_off; !en |-> !SDO_OE_OUT; endproperty
    a_sdo_off: assert property (p_sdo_off) else $error("data driven while disabled");
    property p_sck_half; en && $past(en, 3) && $changed(SCK_OUT) |=> $stable(SCK_OUT); endproperty
    a_sck_half: assert property (p_sck_half) else $error("clock half period too short");
    c_br_run: cover property (rd && WB_ADR_IN == ssb_pkg::ADR_BR && en);
    c_master: cover property ($rose(SCK_OE_OUT));
    c_unmap: cover property (rd && WB_ADR_IN[7:2] > 6'h04);
    c_slave: cover property (SDO_OE_OUT && !SCK_OE_OUT);
endmodule : ssb_assertions

bind ssb_top ssb_assertions u_chk (
    .SYS_CLK_IN, .SYS_RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_DAT_IN,
    .WB_DAT_OUT, .WB_ACK_OUT, .SCK_OUT, .SCK_OE_OUT, .SDO_OE_OUT
);

// file: testbench/ssb_spi_peer.sv
module ssb_spi_peer (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        sck_in,
    input  wire logic        sck_oe_in,
    input  wire logic        sdo_in,
    input  wire logic        sdo_oe_in,
    input  wire logic        cpol_in,
    input  wire logic        cpha_in,
    input  wire logic        lsb_in,
    input  wire logic [4:0]  width_in,
    input  wire logic [15:0] tx_in,
    output logic             miso_out,
    output logic      [15:0] rx_out,
    output int               frames_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q;
    int   ne;
    function automatic int pos(input int n);
        return lsb_in ? n : int'(width_in) - 1 - n;
    endfunction : pos
    // released clock line is pulled to idle level
    wire logic sck = sck_oe_in ? sck_in : cpol_in;
    // a frame only opens on a leading edge; stray idle moves are ignored
    wire logic chg = (sck != sck_q) && !(ne == 0 && sck == cpol_in);
    wire logic smp = chg && (ne[0] == cpha_in);
    wire logic d   = sdo_oe_in ? sdo_in : ~rx_out[pos(ne / 2)];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_q      <= 1'b0;
            ne         <= 0;
            miso_out   <= 1'b0;
            rx_out     <= 16'h0;
            frames_out <= 0;
        end else begin
            sck_q <= sck;
            if (smp) begin
                rx_out[pos(ne / 2)] <= d;
                if (ne / 2 == int'(width_in) - 1) begin
                    frames_out <= frames_out + 1;
                end
            end else if (chg) begin
                miso_out <= tx_in[pos(((ne + 1) / 2) % int'(width_in))];
            end else if (ne == 0) begin
                miso_out <= cpha_in ? ~miso_out : tx_in[pos(0)];
            end
            if (chg) begin
                ne <= (ne == 2 * int'(width_in) - 1) ? 0 : ne + 1;
            end
        end
    end
endmodule : ssb_spi_peer

// file: testbench/sync_serial_channel_bitrate_test.sv
module sync_serial_channel_bitrate_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, cyc, stb, we, ack, sck, sck_oe, sdo, sdo_oe, miso, sck_d;
    logic        cpol, cpha, lsb, ssck, ssel_n;
    logic [4:0]  wid;
    logic [7:0]  adr;
    logic [15:0] ptx, prx;
    logic [31:0] wdat, rdat, q, f1;
    int          frames, miscompares, n_checks, cycles, per, pcnt;
    ssb_top u_dut (
        .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .SCK_IN(ssck), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe),
        .SDI_IN(miso), .SEL_N_IN(ssel_n)
    );
    ssb_spi_peer u_peer (
        .clk_in(clk), .rst_in(rst), .sck_in(sck_oe ? sck : ssck), .sck_oe_in(sck_oe | ~ssel_n),
        .sdo_in(sdo), .sdo_oe_in(sdo_oe),
        .cpol_in(cpol), .cpha_in(cpha), .lsb_in(lsb), .width_in(wid), .tx_in(ptx), .miso_out(miso),
        .rx_out(prx), .frames_out(frames)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================
    // bus, compare and closing
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= dat;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_stat(input int b);
        q = 32'h0;
        while (q[b] !== 1'b1) wb(1'b0, ssb_pkg::ADR_STAT, 32'h0);
    endtask : wait_stat
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // ==========================
    // scenarios
    task automatic t_reset();
        wb(1'b0, ssb_pkg::ADR_CTRL, 32'h0);
        check(q, ssb_pkg::CTRL_RESET);
        wb(1'b0, ssb_pkg::ADR_BR, 32'h0);
        check(q[15:0], ssb_pkg::BR_RESET);
        wb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
    endtask : t_reset
    task automatic t_reload();
        wb(1'b1, ssb_pkg::ADR_BR, 32'h1234);
        wb(1'b0, ssb_pkg::ADR_BR, 32'h0);
        check(q, 32'h1234);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h1);
        wb(1'b0, ssb_pkg::ADR_BR, 32'h0);
        f1 = q;
        wb(1'b0, ssb_pkg::ADR_BR, 32'h0);
        // reads are three clocks apart and the count steps every second clock
        check(32'(f1 - q == 1 || f1 - q == 2), 32'h1);
        // written while running on purpose: must be dropped
        wb(1'b1, ssb_pkg::ADR_BR, 32'h0055);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0);
        wb(1'b0, ssb_pkg::ADR_BR, 32'h0);
        check(q, 32'h1234);
    endtask : t_reload
    task automatic t_modes();
        logic [31:0] ctl, msk;
        for (int m = 0; m < 4; m++) begin
            f1   = 32'(frames);
            msk  = (32'h1 << (4 + 4 * m)) - 1;
            cpol <= m[1];
            cpha <= m[0];
            lsb  <= m[0] ^ m[1];
            wid  <= 5'(4 + 4 * m);
            ptx  <= 16'hc3a5 ^ 16'(m);
            ctl  = {20'h0, 4'(3 + 4 * m), 2'b0, m == 2, m[0] ^ m[1], m[0], m[1], 2'b10};
            wb(1'b1, ssb_pkg::ADR_BR, 32'(m + 1));
            wb(1'b1, ssb_pkg::ADR_CTRL, ctl);
            wb(1'b1, ssb_pkg::ADR_TX, 32'h5a3c ^ 32'(m));
            wb(1'b1, ssb_pkg::ADR_CTRL, ctl | 32'h1);
            wait_stat(ssb_pkg::STA_RXFULL);
            wb(1'b0, ssb_pkg::ADR_RX, 32'h0);
            check(q, 32'(16'hc3a5 ^ 16'(m)) & msk);
            check(32'(prx) & msk, (32'h5a3c ^ 32'(m)) & msk);
            check(32'(per), 32'(2 * (m + 2)));
            check(32'(frames) - f1, 32'h1);
            if (m == 2) check(32'(sdo_oe), 32'h0);
            wb(1'b1, ssb_pkg::ADR_CTRL, ctl);
        end
    endtask : t_modes
    task automatic t_fifo();
        f1   = 32'(frames);
        cpol <= 1'b0;
        cpha <= 1'b0;
        lsb  <= 1'b0;
        wid  <= 5'd8;
        ptx  <= 16'h0096;
        wb(1'b1, ssb_pkg::ADR_BR, 32'h1);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0702);
        for (int i = 0; i < 8; i++) wb(1'b1, ssb_pkg::ADR_TX, 32'(8'h11 * (i + 1)));
        wb(1'b0, ssb_pkg::ADR_STAT, 32'h0);
        check(q & 32'h0f18, 32'h0808);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0703);
        while (32'(frames) < f1 + 8) @(posedge clk);
        wait_stat(ssb_pkg::STA_TXEMP);
        check(32'(prx[7:0]), 32'h88);
        wb(1'b0, ssb_pkg::ADR_STAT, 32'h0);
        check(q & 32'h0f1c, 32'h0014);
        wb(1'b0, ssb_pkg::ADR_RX, 32'h0);
        check(q, 32'h96);
        // rx read clears the full flag, a one written clears overrun
        wb(1'b1, ssb_pkg::ADR_STAT, 32'h4);
        wb(1'b0, ssb_pkg::ADR_STAT, 32'h0);
        check(q & 32'h6, 32'h0);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0702);
    endtask : t_fifo
    task automatic t_slave();
        f1 = 32'(frames);
        {cpol, cpha, lsb, wid, ptx} <= {3'b010, 5'd8, 16'h00e7};
        wb(1'b1, ssb_pkg::ADR_TX, 32'h005b);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0709);
        ssel_n <= 1'b0;
        repeat (2) @(posedge clk);
        // bench is the external master: 16 clock edges, 3 cycles apart
        repeat (16) begin
            ssck <= ~ssck;
            repeat (3) @(posedge clk);
        end
        // deselect cuts the empty word that restarts behind the first
        ssel_n <= 1'b1;
        wb(1'b0, ssb_pkg::ADR_RX, 32'h0);
        check(q, 32'he7);
        check(32'(prx[7:0]), 32'h5b);
        check(32'(frames) - f1, 32'h1);
        wb(1'b1, ssb_pkg::ADR_CTRL, 32'h0708);
    endtask : t_slave
    // ==========================
    // clock period monitor and hang limit
    always @(posedge clk) begin
        sck_d  <= sck;
        pcnt   <= (sck && !sck_d) ? 1 : pcnt + 1;
        cycles <= cycles + 1;
        if (sck && !sck_d) per <= pcnt;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        {rst, cyc, stb, we, adr, wdat, sck_d, ssck, ssel_n} = {1'b1, 45'h0, 1'b1};
        {cpol, cpha, lsb, wid, ptx} = {3'b0, 5'd8, 16'h0};
        {miscompares, n_checks, cycles, per, pcnt} = {5{32'sd0}};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_reload();
        t_modes();
        t_fifo();
        t_slave();
        finish_test();
    end
endmodule : sync_serial_channel_bitrate_test
